// [src/pmt_ctrl.sv]
// program pacing and measurement trigger controller with an AXI4-Lite register slave
// Overview of operation
// [RULE1] measurement-end pacing only takes effect when the measurement option is fitted
// [RULE2] run starts at step 1 and advances one step per interval expiry
// [RULE3] step runs the current step only and stops when the interval expires
// [RULE4] hold pauses a running program; hold again resumes at the same point
// [RULE5] a falling edge on either trigger input behaves as a step request
// [RULE6] measurement-end pacing advances the step when the measurement completes
// [RULE7] software must choose settle-done measurement triggering with measurement-end pacing
// [RULE8] with measurement-end pacing run, step, hold keys and the interval are ignored
// [RULE9] timer triggers every 0.1 to 3600.0 s period, restarts when output turns on
// [RULE10] back-to-back mode starts the next measurement when one completes
// [RULE11] settle-done mode triggers a measurement 10 ms after each level change
// [RULE12] host trigger command starts a measurement in host-message mode
// [RULE13] program trigger is sent on both chain and coaxial outputs
// [RULE14] interval pacing: busy low on program trigger, high when interval expires
// [RULE15] measurement-end pacing: busy pulses low one cycle per program trigger
// [RULE16] host hold, pause and continue commands pause and resume the program
// [RULE17] measurement trigger during a measurement sets the sampling error
// [RULE18] run, step or trigger edge while a program runs sets the sampling error
// [RULE19] trigger inputs pass two flops; each falling edge is one single-cycle event
// [RULE20] sampling error stays set until reset or an explicit clear
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module pmt_ctrl
#(
  parameter int unsigned P_TICK_CYC   = pmt_pkg::TICK_CYC,
  parameter int unsigned P_SETTLE_CYC = pmt_pkg::SETTLE_CYC
)
(
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_measurement_option,
  input  wire logic        i_key_run,
  input  wire logic        i_key_step,
  input  wire logic        i_key_hold,
  input  wire logic        i_external_trigger_input_chain,
  input  wire logic        i_external_trigger_input_coax,
  input  wire logic        i_meas_done,
  input  wire logic        i_level_change,
  output logic             o_prog_trig,
  output logic [15:0]      o_step_num,
  output logic             o_running,
  output logic             o_meas_start,
  output logic             o_trigger_busy_out_chain,
  output logic             o_trigger_busy_out_coax,
  output logic             o_sampling_err,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready
);
  import pmt_pkg::*;

  typedef struct packed {
    pmt_prog_e   prog;
    logic        active;
    logic        ret_step;
    logic        adv_pend;
    logic [31:0] icnt;
    logic [15:0] step_idx;
    logic        busy_n;
    logic        prog_trig;
    logic        meas_start;
    logic        meas_busy;
    logic        samp_err;
    logic [31:0] tick_cnt;
    logic [15:0] per_cnt;
    logic        settle_act;
    logic [31:0] settle_cnt;
    logic        mend;
    pmt_msrc_e   msrc;
    logic        out_on;
    logic        out_on_prev;
    logic [31:0] interval;
    logic [15:0] period;
    logic [2:0]  chain_s;
    logic [2:0]  coax_s;
    logic [1:0]  opt_s;
    logic        aw_have;
    logic [7:0]  awaddr;
    logic        w_have;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } pmt_state_s;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (strb[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    return r;
  endfunction

  function automatic logic [15:0] clamp_period(input logic [15:0] p);
    if (p < PERIOD_MIN_T) return PERIOD_MIN_T;
    if (p > PERIOD_MAX_T) return PERIOD_MAX_T;
    return p;
  endfunction

  pmt_state_s s_ff;
  pmt_state_s nxt_s;
  logic       ext_fall;
  logic       mend;
  logic       wr_go;
  logic [7:0] cmd;
  logic       running;
  logic       run_req;
  logic       step_req;
  logic       pause_req;
  logic       resume_req;
  logic       expire;
  logic       tick;
  logic       t_fire;
  logic       s_fire;
  logic       meas_req;
  logic [31:0] ctrl_w;
  logic [31:0] per_w;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.prog_trig = 1'b0;
    nxt_s.meas_start = 1'b0;
    // two-flop synchronisers, third stage only for edge detection
    nxt_s.chain_s = {s_ff.chain_s[1:0], i_external_trigger_input_chain}; // RULE19
    nxt_s.coax_s = {s_ff.coax_s[1:0], i_external_trigger_input_coax}; // RULE19
    nxt_s.opt_s = {s_ff.opt_s[0], i_measurement_option};
    ext_fall = (s_ff.chain_s[2] & ~s_ff.chain_s[1]) | (s_ff.coax_s[2] & ~s_ff.coax_s[1]); // RULE19
    mend = s_ff.mend & s_ff.opt_s[1]; // RULE1

    // register write channel
    if (i_awvalid && s_ff.awready)
    begin
      nxt_s.aw_have = 1'b1;
      nxt_s.awaddr = i_awaddr;
      nxt_s.awready = 1'b0;
    end
    if (i_wvalid && s_ff.wready)
    begin
      nxt_s.w_have = 1'b1;
      nxt_s.wdata = i_wdata;
      nxt_s.wstrb = i_wstrb;
      nxt_s.wready = 1'b0;
    end
    wr_go = s_ff.aw_have & s_ff.w_have & ~s_ff.bvalid;
    cmd = 8'h00;
    ctrl_w = wmerge({28'h0, s_ff.out_on, s_ff.msrc, s_ff.mend}, s_ff.wdata, s_ff.wstrb);
    per_w = wmerge({16'h0, s_ff.period}, s_ff.wdata, s_ff.wstrb);
    if (wr_go)
    begin
      nxt_s.aw_have = 1'b0;
      nxt_s.w_have = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = RESP_OKAY;
      case (s_ff.awaddr)
        ADDR_CTRL:
        begin
          nxt_s.mend = ctrl_w[CTRL_MEND_BIT];
          nxt_s.msrc = pmt_msrc_e'(ctrl_w[CTRL_MSRC_LSB +: 2]);
          nxt_s.out_on = ctrl_w[CTRL_OUTON_BIT];
        end
        ADDR_INTERVAL: nxt_s.interval = wmerge(s_ff.interval, s_ff.wdata, s_ff.wstrb);
        ADDR_PERIOD:
          nxt_s.period = clamp_period(per_w[15:0]); // RULE9
        ADDR_CMD: cmd = s_ff.wstrb[0] ? s_ff.wdata[7:0] : 8'h00;
        ADDR_STATUS: ;
        default: nxt_s.bresp = RESP_SLVERR;
      endcase
    end
    if (s_ff.bvalid && i_bready)
    begin
      nxt_s.bvalid = 1'b0;
      nxt_s.awready = 1'b1;
      nxt_s.wready = 1'b1;
    end

    // register read channel
    if (i_arvalid && s_ff.arready)
    begin
      nxt_s.arready = 1'b0;
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = RESP_OKAY;
      nxt_s.rdata = 32'h0;
      case (i_araddr)
        ADDR_CTRL: nxt_s.rdata = {28'h0, s_ff.out_on, s_ff.msrc, s_ff.mend};
        ADDR_INTERVAL: nxt_s.rdata = s_ff.interval;
        ADDR_PERIOD: nxt_s.rdata = {16'h0, s_ff.period};
        ADDR_CMD: ;
        ADDR_STATUS:
        begin
          nxt_s.rdata[ST_RUNNING] = (s_ff.prog == PMT_RUN) || (s_ff.prog == PMT_STEP);
          nxt_s.rdata[ST_PAUSED] = s_ff.prog == PMT_PAUSE;
          nxt_s.rdata[ST_SERR] = s_ff.samp_err;
          nxt_s.rdata[ST_MBUSY] = s_ff.meas_busy;
          nxt_s.rdata[ST_MEND] = mend;
          nxt_s.rdata[ST_OPTION] = s_ff.opt_s[1];
          nxt_s.rdata[ST_STEP_LSB +: 16] = s_ff.step_idx;
        end
        default: nxt_s.rresp = RESP_SLVERR;
      endcase
    end
    if (s_ff.rvalid && i_rready)
    begin
      nxt_s.rvalid = 1'b0;
      nxt_s.arready = 1'b1;
    end

    // program pacing
    running = (s_ff.prog == PMT_RUN) || (s_ff.prog == PMT_STEP);
    run_req = (i_key_run & ~mend) | cmd[CMD_RUN]; // RULE8
    step_req = ((i_key_step | ext_fall) & ~mend) | cmd[CMD_STEP]; // RULE5 RULE8
    pause_req = (i_key_hold & ~mend) | cmd[CMD_HOLD] | cmd[CMD_PAUSE]; // RULE16
    resume_req = (i_key_hold & ~mend) | cmd[CMD_HOLD] | cmd[CMD_CONT]; // RULE16
    expire = running && ({1'b0, s_ff.icnt} + 33'h1 >= {1'b0, s_ff.interval});
    if (mend && !s_ff.busy_n)
      nxt_s.busy_n = 1'b1; // RULE15
    unique case (s_ff.prog)
      PMT_IDLE:
        if (run_req)
        begin
          nxt_s.prog = PMT_RUN; // RULE2
          nxt_s.step_idx = STEP_FIRST;
          nxt_s.icnt = 32'h0;
          nxt_s.adv_pend = 1'b0;
          nxt_s.prog_trig = 1'b1; // RULE13
          nxt_s.busy_n = 1'b0; // RULE14 RULE15
        end
        else if (step_req && !mend)
        begin
          nxt_s.prog = PMT_STEP; // RULE3
          nxt_s.icnt = 32'h0;
          nxt_s.prog_trig = 1'b1;
          nxt_s.busy_n = 1'b0;
        end
      PMT_RUN:
        if (cmd[CMD_STOP])
        begin
          nxt_s.prog = PMT_IDLE;
          nxt_s.busy_n = 1'b1;
        end
        else if (pause_req)
        begin
          nxt_s.prog = PMT_PAUSE; // RULE4
          nxt_s.ret_step = 1'b0;
        end
        else if (mend)
        begin
          if (i_meas_done)
          begin
            nxt_s.step_idx = s_ff.step_idx + 16'h1; // RULE6
            nxt_s.prog_trig = 1'b1;
            nxt_s.busy_n = 1'b0; // RULE15
          end
        end
        else if (s_ff.adv_pend)
        begin
          nxt_s.adv_pend = 1'b0;
          nxt_s.step_idx = s_ff.step_idx + 16'h1; // RULE2
          nxt_s.icnt = 32'h0;
          nxt_s.prog_trig = 1'b1;
          nxt_s.busy_n = 1'b0; // RULE14
        end
        else if (expire)
        begin
          nxt_s.busy_n = 1'b1; // RULE14
          nxt_s.adv_pend = 1'b1;
        end
        else
          nxt_s.icnt = s_ff.icnt + 32'h1;
      PMT_STEP:
        if (cmd[CMD_STOP])
        begin
          nxt_s.prog = PMT_IDLE;
          nxt_s.busy_n = 1'b1;
        end
        else if (pause_req)
        begin
          nxt_s.prog = PMT_PAUSE;
          nxt_s.ret_step = 1'b1;
        end
        else if (expire)
        begin
          nxt_s.prog = PMT_IDLE; // RULE3
          nxt_s.busy_n = 1'b1; // RULE14
          nxt_s.step_idx = s_ff.step_idx + 16'h1;
        end
        else
          nxt_s.icnt = s_ff.icnt + 32'h1;
      PMT_PAUSE:
        if (cmd[CMD_STOP])
        begin
          nxt_s.prog = PMT_IDLE;
          nxt_s.busy_n = 1'b1;
        end
        else if (resume_req)
          nxt_s.prog = s_ff.ret_step ? PMT_STEP : PMT_RUN; // RULE4
    endcase
    nxt_s.active = (nxt_s.prog == PMT_RUN) || (nxt_s.prog == PMT_STEP);

    // measurement timer in 0.1 s ticks, restarted when the output turns on
    nxt_s.out_on_prev = s_ff.out_on;
    tick = 1'b0;
    t_fire = 1'b0;
    if (s_ff.out_on && !s_ff.out_on_prev)
    begin
      nxt_s.tick_cnt = 32'h0; // RULE9
      nxt_s.per_cnt = 16'h0;
    end
    else if (s_ff.tick_cnt >= 32'(P_TICK_CYC - 1))
    begin
      nxt_s.tick_cnt = 32'h0;
      tick = 1'b1;
    end
    else
      nxt_s.tick_cnt = s_ff.tick_cnt + 32'h1;
    if (tick)
    begin
      if (s_ff.per_cnt + 16'h1 >= s_ff.period)
      begin
        nxt_s.per_cnt = 16'h0;
        t_fire = 1'b1; // RULE9
      end
      else
        nxt_s.per_cnt = s_ff.per_cnt + 16'h1;
    end

    // settle delay after a level change
    s_fire = 1'b0;
    if (i_level_change)
    begin
      nxt_s.settle_act = 1'b1;
      nxt_s.settle_cnt = 32'h0;
    end
    else if (s_ff.settle_act)
    begin
      if (s_ff.settle_cnt >= 32'(P_SETTLE_CYC - 1))
      begin
        nxt_s.settle_act = 1'b0;
        s_fire = 1'b1; // RULE11
      end
      else
        nxt_s.settle_cnt = s_ff.settle_cnt + 32'h1;
    end

    // measurement start; the host trigger also kicks off back-to-back mode
    unique case (s_ff.msrc)
      MSRC_TIMER: meas_req = t_fire;
      MSRC_IMMED: meas_req = i_meas_done | cmd[CMD_TRG]; // RULE10
      MSRC_READY: meas_req = s_fire; // RULE7 RULE11
      MSRC_COMM: meas_req = cmd[CMD_TRG]; // RULE12
    endcase
    meas_req = meas_req & s_ff.opt_s[1];
    if (i_meas_done)
      nxt_s.meas_busy = 1'b0;
    if (cmd[CMD_CLR])
      nxt_s.samp_err = 1'b0; // RULE20
    if (meas_req)
    begin
      if (s_ff.meas_busy && !i_meas_done)
        nxt_s.samp_err = 1'b1; // RULE17
      else
      begin
        nxt_s.meas_start = 1'b1;
        nxt_s.meas_busy = 1'b1;
      end
    end
    if ((run_req || step_req) && running)
      nxt_s.samp_err = 1'b1; // RULE18
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      s_ff <= '0;
      s_ff.prog <= PMT_IDLE;
      s_ff.msrc <= MSRC_TIMER;
      s_ff.step_idx <= STEP_FIRST;
      s_ff.busy_n <= 1'b1;
      s_ff.interval <= INTERVAL_RST;
      s_ff.period <= PERIOD_RST;
      s_ff.chain_s <= 3'h7;
      s_ff.coax_s <= 3'h7;
      s_ff.awready <= 1'b1;
      s_ff.wready <= 1'b1;
      s_ff.arready <= 1'b1;
    end
    else
      s_ff <= nxt_s;
  end

  assign o_prog_trig = s_ff.prog_trig;
  assign o_step_num = s_ff.step_idx;
  assign o_running = s_ff.active;
  assign o_meas_start = s_ff.meas_start;
  assign o_trigger_busy_out_chain = s_ff.busy_n; // RULE13
  assign o_trigger_busy_out_coax = s_ff.busy_n; // RULE13
  assign o_sampling_err = s_ff.samp_err;
  assign o_awready = s_ff.awready;
  assign o_wready = s_ff.wready;
  assign o_bresp = s_ff.bresp;
  assign o_bvalid = s_ff.bvalid;
  assign o_arready = s_ff.arready;
  assign o_rdata = s_ff.rdata;
  assign o_rresp = s_ff.rresp;
  assign o_rvalid = s_ff.rvalid;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  property p_run_start;
    (s_ff.prog == PMT_IDLE && run_req) |=> (s_ff.prog == PMT_RUN && s_ff.step_idx == STEP_FIRST && s_ff.prog_trig);
  endproperty
  a_run_start: assert property (p_run_start) else $error("run did not start at first step"); // RULE2

  property p_ext_step;
    (s_ff.prog == PMT_IDLE && ext_fall && !mend && !run_req) |=> (s_ff.prog == PMT_STEP && s_ff.prog_trig);
  endproperty
  a_ext_step: assert property (p_ext_step) else $error("trigger edge did not act as step"); // RULE5

  property p_busy_norm;
    (s_ff.prog == PMT_RUN && !mend && s_ff.adv_pend && !pause_req && !cmd[CMD_STOP])
      |=> (!s_ff.busy_n && s_ff.prog_trig);
  endproperty
  a_busy_norm: assert property (p_busy_norm) else $error("busy not low on interval trigger"); // RULE14

  property p_busy_mend;
    (mend && $fell(s_ff.busy_n)) |=> s_ff.busy_n;
  endproperty
  a_busy_mend: assert property (p_busy_mend) else $error("busy pulse longer than one cycle"); // RULE15

  property p_meas_overrun;
    (meas_req && s_ff.meas_busy && !i_meas_done) |=> (s_ff.samp_err && !s_ff.meas_start);
  endproperty
  a_meas_overrun: assert property (p_meas_overrun) else $error("overrun did not flag error"); // RULE17

  property p_prog_overrun;
    ((run_req || step_req) && running) |=> s_ff.samp_err;
  endproperty
  a_prog_overrun: assert property (p_prog_overrun) else $error("request while running not flagged"); // RULE18

  property p_err_sticky;
    $fell(s_ff.samp_err) |-> $past(cmd[CMD_CLR]);
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error cleared without request"); // RULE20

  property p_keys_ignored;
    (mend && s_ff.prog == PMT_IDLE && !cmd[CMD_RUN] && !cmd[CMD_STEP]) |=> (s_ff.prog == PMT_IDLE);
  endproperty
  a_keys_ignored: assert property (p_keys_ignored) else $error("key acted under end pacing"); // RULE8

  property p_pause_hold;
    (s_ff.prog == PMT_PAUSE && !resume_req && !cmd[CMD_STOP]) |=> ($stable(s_ff.icnt) && s_ff.prog == PMT_PAUSE);
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("paused program moved"); // RULE4

  property p_immed;
    (s_ff.msrc == MSRC_IMMED && s_ff.opt_s[1] && i_meas_done) |=> s_ff.meas_start;
  endproperty
  a_immed: assert property (p_immed) else $error("no back-to-back restart"); // RULE10

  property p_mend_adv;
    (mend && s_ff.prog == PMT_RUN && i_meas_done && !pause_req && !cmd[CMD_STOP])
      |=> (s_ff.prog_trig && s_ff.step_idx == $past(s_ff.step_idx) + 16'h1);
  endproperty
  a_mend_adv: assert property (p_mend_adv) else $error("no advance on measurement end"); // RULE6
endmodule // pmt_ctrl
`default_nettype wire

// [src/pmt_pkg.sv]
// constants and types shared by the program and measurement trigger controller
package pmt_pkg;
  // clock and derived timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TICK_NS       = 100_000_000;
  localparam int unsigned TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_NS     = 10_000_000;
  localparam int unsigned SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // measurement timer period limits, in 0.1 s ticks
  localparam logic [15:0] PERIOD_MIN_T  = 16'h0001;
  localparam logic [15:0] PERIOD_MAX_T  = 16'h8ca0;
  // register byte offsets
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_INTERVAL = 8'h04;
  localparam logic [7:0]  ADDR_PERIOD   = 8'h08;
  localparam logic [7:0]  ADDR_CMD      = 8'h0c;
  localparam logic [7:0]  ADDR_STATUS   = 8'h10;
  // control fields
  localparam int          CTRL_MEND_BIT = 0;
  localparam int          CTRL_MSRC_LSB = 1;
  localparam int          CTRL_OUTON_BIT = 3;
  // command bits, write one to act
  localparam int          CMD_RUN       = 0;
  localparam int          CMD_STEP      = 1;
  localparam int          CMD_HOLD      = 2;
  localparam int          CMD_PAUSE     = 3;
  localparam int          CMD_CONT      = 4;
  localparam int          CMD_STOP      = 5;
  localparam int          CMD_TRG       = 6;
  localparam int          CMD_CLR       = 7;
  // status fields
  localparam int          ST_RUNNING    = 0;
  localparam int          ST_PAUSED     = 1;
  localparam int          ST_SERR       = 2;
  localparam int          ST_MBUSY      = 3;
  localparam int          ST_MEND       = 4;
  localparam int          ST_OPTION     = 5;
  localparam int          ST_STEP_LSB   = 16;
  // reset values
  localparam logic [31:0] INTERVAL_RST  = 32'h0000_c350;
  localparam logic [15:0] PERIOD_RST    = 16'h000a;
  localparam logic [15:0] STEP_FIRST    = 16'h0001;
  // bus responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {PMT_IDLE, PMT_RUN, PMT_STEP, PMT_PAUSE} pmt_prog_e;
  typedef enum logic [1:0] {MSRC_TIMER, MSRC_IMMED, MSRC_READY, MSRC_COMM} pmt_msrc_e;
endpackage

// [sim/pmt_far_model.sv]
// far side model: measurement engine, source level steps and trigger pins of an upstream unit
`timescale 1ns/10ps
`default_nettype none
module pmt_far_model
#(
  parameter int P_LAT = 30
)
(
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_meas_start,
  input  wire logic       i_prog_trig,
  input  wire logic [1:0] i_fall,
  output logic            o_meas_done,
  output logic            o_level_change,
  output logic [1:0]      o_pin
);
  int mcnt = 0;
  int pcnt [2] = '{0, 0};
  // each program trigger changes the source level; a measurement takes P_LAT cycles
  always @(posedge i_clk)
  begin
    o_level_change <= i_prog_trig & ~i_srst;
    o_meas_done    <= (mcnt == 1);
    if (i_srst || i_meas_start)
      mcnt <= i_srst ? 0 : P_LAT;
    else if (mcnt > 0)
      mcnt <= mcnt - 1;
    // pins idle high through pull-ups; a request pulls a pin low for a few cycles
    for (int k = 0; k < 2; k++)
    begin
      pcnt[k]  <= i_fall[k] ? 4 : (pcnt[k] > 0 ? pcnt[k] - 1 : 0);
      o_pin[k] <= !(i_fall[k] || pcnt[k] > 1);
    end
  end
endmodule // pmt_far_model
`default_nettype wire

// [sim/test_program_measure_trigger_ctrl.sv]
// testbench for the program and measurement trigger controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    checks_done++; \
    if ((got) !== (ex)) \
    begin \
      failures++; \
      $display("mismatch %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module test_program_measure_trigger_ctrl;
  import pmt_pkg::*;
  localparam int N_IV = 8;
  logic i_clk = 0, i_srst = 1, opt = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [2:0] key = 0;
  logic [1:0] fall = 0, bresp, rresp, rr, pin;
  logic [3:0] wstrb = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [15:0] step, s0;
  logic trig, running, mst, bsy_ch, bsy_cx, serr, awready, wready, bvalid, arready, rvalid, mdone, lvl;
  int failures = 0, checks_done = 0, n;

  pmt_ctrl #(.P_TICK_CYC(20), .P_SETTLE_CYC(10)) uut (.i_clk(i_clk), .i_srst(i_srst),
    .i_measurement_option(opt), .i_key_run(key[0]), .i_key_step(key[1]), .i_key_hold(key[2]),
    .i_external_trigger_input_chain(pin[0]), .i_external_trigger_input_coax(pin[1]),
    .i_meas_done(mdone), .i_level_change(lvl), .o_prog_trig(trig), .o_step_num(step),
    .o_running(running), .o_meas_start(mst), .o_trigger_busy_out_chain(bsy_ch),
    .o_trigger_busy_out_coax(bsy_cx), .o_sampling_err(serr), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));
  pmt_far_model #(.P_LAT(30)) far (.i_clk(i_clk), .i_srst(i_srst), .i_meas_start(mst),
    .i_prog_trig(trig), .i_fall(fall), .o_meas_done(mdone), .o_level_change(lvl), .o_pin(pin));

  initial
  begin
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    rr = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdx(input logic [7:0] a);
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m);
    rdx(a);
    `CHK(nm, ex, rd & m)
  endtask

  task automatic cmd(input int b);
    wr(ADDR_CMD, 32'h1 << b);
  endtask

  // one-cycle key pulse, or a falling edge on a trigger pin
  task automatic press(input int k, input bit p);
    @(posedge i_clk);
    if (p)
      fall[k] <= 1'b1;
    else
      key[k] <= 1'b1;
    @(posedge i_clk);
    fall <= 2'h0;
    key <= 3'h0;
  endtask

  // wait for a program trigger (ms=0) or measurement start (ms=1), n counts cycles
  task automatic ev(input bit ms, input int lim);
    n = 0;
    #1;
    while (((ms ? mst : trig) !== 1'b1) && n < lim)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
  endtask

  task automatic end_of_test;
    if (failures == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge i_clk);
    failures++;
    end_of_test();
  end

  initial
  begin
    repeat (20) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    #1;
    `CHK("step", 16'h1, step)
    `CHK("busy", 2'h3, {bsy_ch, bsy_cx})
    `CHK("idle", 2'h0, {serr, running})
    wr(ADDR_CTRL, 32'h1);
    `CHK("bresp", RESP_OKAY, rr)
    rdchk("mend", ADDR_STATUS, 32'h0, 32'h1 << ST_MEND);
    @(posedge i_clk);
    opt <= 1'b1;
    // let the option level pass its synchroniser
    repeat (2) @(posedge i_clk);
    rdchk("mend", ADDR_STATUS, 32'h1 << ST_MEND, 32'h1 << ST_MEND);
    rdx(8'h14);
    `CHK("resp", RESP_SLVERR, rr)
    wr(8'h14, 32'h0);
    `CHK("bresp", RESP_SLVERR, rr)
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_INTERVAL, N_IV);
    press(0, 0);
    ev(0, 10);
    `CHK("run", 4'hd, {trig, running, step[1:0]})
    `CHK("busy", 2'h0, {bsy_ch, bsy_cx})
    @(posedge i_clk);
    ev(0, 30);
    `CHK("gap", N_IV, n)
    `CHK("step", 16'h2, step)
    press(1, 0);
    repeat (20) @(posedge i_clk);
    `CHK("serr", 1'b1, serr)
    cmd(CMD_CLR);
    #1;
    `CHK("serr", 1'b0, serr)
    press(2, 0);
    ev(0, 40);
    `CHK("held", 1'b0, trig)
    press(2, 0);
    ev(0, N_IV + 2);
    `CHK("resume", 1'b1, trig)
    cmd(CMD_PAUSE);
    rdchk("pause", ADDR_STATUS, 32'h1 << ST_PAUSED, 32'h1 << ST_PAUSED);
    cmd(CMD_CONT);
    rdchk("pause", ADDR_STATUS, 32'h0, 32'h1 << ST_PAUSED);
    cmd(CMD_STOP);
    repeat (3) @(posedge i_clk);
    s0 = step;
    press(0, 1);
    ev(0, 10);
    `CHK("ext", 1'b1, trig)
    repeat (N_IV + 3) @(posedge i_clk);
    #1;
    `CHK("stepdone", {1'b0, s0 + 16'h1}, {running, step})
    press(1, 1);
    ev(0, 10);
    press(0, 1);
    repeat (8) @(posedge i_clk);
    `CHK("serr", 1'b1, serr)
    cmd(CMD_CLR);
    wr(ADDR_INTERVAL, 1000);
    wr(ADDR_CTRL, 32'h5);
    press(0, 0);
    ev(0, 20);
    `CHK("keyoff", 1'b0, trig)
    // command pulses land at the edge that raises bvalid, so watch while the write runs
    fork
      cmd(CMD_RUN);
      begin
        ev(0, 10);
        `CHK("mbusy", 2'h2, {trig, bsy_ch})
        @(posedge i_clk);
        #1;
        `CHK("mbusy", 1'b1, bsy_ch)
      end
    join
    ev(1, 30);
    `CHK("settle", 2'h3, {mst, n >= 8})
    @(posedge i_clk);
    ev(0, 50);
    `CHK("mend", 1'b1, trig)
    cmd(CMD_STOP);
    wr(ADDR_CTRL, 32'h6);
    fork
      cmd(CMD_TRG);
      begin
        ev(1, 10);
        `CHK("host", 1'b1, mst)
      end
    join
    cmd(CMD_TRG);
    repeat (3) @(posedge i_clk);
    `CHK("serr", 1'b1, serr)
    cmd(CMD_CLR);
    repeat (40) @(posedge i_clk);
    wr(ADDR_CTRL, 32'h2);
    fork
      cmd(CMD_TRG);
      begin
        ev(1, 10);
        `CHK("kick", 1'b1, mst)
      end
    join
    @(posedge i_clk);
    ev(1, 40);
    `CHK("immed", 1'b1, mst)
    wr(ADDR_PERIOD, 32'h0);
    rdchk("pmin", ADDR_PERIOD, {16'h0, PERIOD_MIN_T}, 32'hffff);
    wr(ADDR_PERIOD, 32'hffff);
    rdchk("pmax", ADDR_PERIOD, {16'h0, PERIOD_MAX_T}, 32'hffff);
    wr(ADDR_PERIOD, 32'h2);
    wr(ADDR_CTRL, 32'h8);
    ev(1, 50);
    @(posedge i_clk);
    ev(1, 50);
    `CHK("timer", 2'h3, {mst, n >= 35})
    end_of_test();
  end
endmodule // test_program_measure_trigger_ctrl
`default_nettype wire
